//--- rtl/dsb_top.sv
// Safety and blanking logic of a monitor deflection controller: latched over-voltage
// trip, ordered phase-in/out of horizontal and converter drives, early vertical blanking
// and a two-bit lock/blank composite code.
// Assumes pins arrive asynchronously and registers are reached over Avalon-MM.
//
// Summary of operation
// - Over-voltage trips drives off only after persisting two horizontal lines.
// - A trip sets the over-voltage alarm flag to one for software.
// - Trip stays latched until supply drop or software clear bit.
// - Every drive switch-on or switch-off uses the same phased sequence.
// - Horizontal drive comes on first and goes off last.
// - Blanking starts at first leading edge of vertical sync or discharge.
// - Blanking ends at trailing edge of discharge pulse only.
// - Composite output encodes lock and blank together, four combinations.
// - Permanent blank select at one holds blank level with current lock.
// - Blank also forced by low supply, active trip, or vertical drive off.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
module dsb_top (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        overvolt_sense_in,
   input  wire logic        hsync_line_in,
   input  wire logic        vsync_in,
   input  wire logic        vdischarge_in,
   input  wire logic        line_pll_lock_in,
   input  wire logic        supply_ok_in,
   output logic             horiz_drive_out,
   output logic             conv_drive_out,
   output logic [1:0]       lock_blank_composite_out
);
   import dsb_pkg::*;

   logic ov_s, hl_s, vs_s, vd_s, lock_s, sup_s;

   dsb_sync u_s_ov (.core_clk(core_clk), .rst(rst), .async_in(overvolt_sense_in),
                    .sync_out(ov_s));
   dsb_sync u_s_hl (.core_clk(core_clk), .rst(rst), .async_in(hsync_line_in),
                    .sync_out(hl_s));
   dsb_sync u_s_vs (.core_clk(core_clk), .rst(rst), .async_in(vsync_in),
                    .sync_out(vs_s));
   dsb_sync u_s_vd (.core_clk(core_clk), .rst(rst), .async_in(vdischarge_in),
                    .sync_out(vd_s));
   dsb_sync u_s_lk (.core_clk(core_clk), .rst(rst), .async_in(line_pll_lock_in),
                    .sync_out(lock_s));
   dsb_sync u_s_sp (.core_clk(core_clk), .rst(rst), .async_in(supply_ok_in),
                    .sync_out(sup_s));

   // Edge history of synchronised signals.
   logic hl_q, vs_q, vd_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hl_q <= 1'b0;
         vs_q <= 1'b0;
         vd_q <= 1'b0;
      end else begin
         hl_q <= hl_s;
         vs_q <= vs_s;
         vd_q <= vd_s;
      end
   end

   logic line_tick;
   assign line_tick = hl_s & ~hl_q;

   // Register file.
   logic        drive_on_q, permanent_blank_sel, vert_drive_enable;
   logic [15:0] seq_gap_q;
   logic        overvolt_latch_clear;
   logic        wr_ctrl;

   assign avs_waitrequest = 1'b0;
   assign wr_ctrl = avs_write && avs_address == CTRL_OFS && avs_byteenable[0];
   // The clear bit is a self-clearing one-cycle strobe, it never reads back as one.
   assign overvolt_latch_clear = wr_ctrl && avs_writedata[CTRL_OV_CLEAR_BIT];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         drive_on_q          <= CTRL_DRIVE_ON_RST;
         permanent_blank_sel <= CTRL_PERM_BLK_RST;
         vert_drive_enable   <= CTRL_VERT_EN_RST;
      end else if (wr_ctrl) begin
         drive_on_q          <= avs_writedata[CTRL_DRIVE_ON_BIT];
         permanent_blank_sel <= avs_writedata[CTRL_PERM_BLK_BIT];
         vert_drive_enable   <= avs_writedata[CTRL_VERT_EN_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         seq_gap_q <= SEQ_GAP_RST;
      end else if (avs_write && avs_address == SEQ_OFS) begin
         if (avs_byteenable[0]) begin
            seq_gap_q[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            seq_gap_q[15:8] <= avs_writedata[15:8];
         end
      end
   end

   // Over-voltage qualification: count horizontal line starts seen with the sense held high.
   logic [1:0] ov_lines_q;
   logic       ov_latched_q;
   logic       overvolt_alarm_flag;

   always_ff @(posedge core_clk) begin
      if (rst || !ov_s) begin
         ov_lines_q <= 2'h0;
      end else if (line_tick && ov_lines_q != 2'(OV_DELAY_LINES)) begin
         ov_lines_q <= ov_lines_q + 2'h1;
      end
   end

   // Supply loss clears the latch like a power-on; a new trip wins over a clear.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ov_latched_q <= 1'b0;
      end else if (ov_lines_q == 2'(OV_DELAY_LINES) && sup_s) begin
         ov_latched_q <= 1'b1;
      end else if (!sup_s || overvolt_latch_clear) begin
         ov_latched_q <= 1'b0;
      end
   end
   assign overvolt_alarm_flag = ov_latched_q;

   // Phase sequencer shared by every on/off cause.
   dsb_phase_type phase_q;
   logic [15:0]   gap_cnt_q;
   logic          want_on;
   logic          gap_done;

   assign want_on  = drive_on_q && sup_s && !ov_latched_q;
   assign gap_done = gap_cnt_q >= seq_gap_q;

   always_ff @(posedge core_clk) begin
      if (rst || phase_q == PH_OFF || phase_q == PH_BOTH) begin
         gap_cnt_q <= 16'h0000;
      end else if (!gap_done) begin
         gap_cnt_q <= gap_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_q <= PH_OFF;
      end else begin
         unique case (phase_q)
            PH_OFF: begin
               if (want_on) begin
                  phase_q <= PH_HORIZ;
               end
            end
            PH_HORIZ: begin
               if (!want_on) begin
                  phase_q <= PH_OFF;
               end else if (gap_done) begin
                  phase_q <= PH_BOTH;
               end
            end
            PH_BOTH: begin
               if (!want_on) begin
                  phase_q <= PH_CONV_OFF;
               end
            end
            PH_CONV_OFF: begin
               if (gap_done) begin
                  phase_q <= PH_OFF;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         horiz_drive_out <= 1'b0;
         conv_drive_out  <= 1'b0;
      end else begin
         horiz_drive_out <= phase_q != PH_OFF;
         conv_drive_out  <= phase_q == PH_BOTH;
      end
   end

   // Early vertical blanking.
   logic vblank_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         vblank_q <= 1'b0;
      end else if (vd_q && !vd_s) begin
         vblank_q <= 1'b0;
      end else if ((vs_s && !vs_q) || (vd_s && !vd_q)) begin
         vblank_q <= 1'b1;
      end
   end

   logic blank_now;
   assign blank_now = vblank_q || permanent_blank_sel
                      || !sup_s || ov_latched_q || !vert_drive_enable;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock_blank_composite_out <= 2'h1;
      end else begin
         lock_blank_composite_out <= {lock_s, blank_now};
      end
   end

   // Read path, answered combinationally with no wait state.
   always_comb begin
      avs_readdata = 32'h0000_0000;
      if (avs_read) begin
         unique case (avs_address)
            CTRL_OFS: begin
               avs_readdata[CTRL_DRIVE_ON_BIT] = drive_on_q;
               avs_readdata[CTRL_PERM_BLK_BIT] = permanent_blank_sel;
               avs_readdata[CTRL_VERT_EN_BIT]  = vert_drive_enable;
            end
            STATUS_OFS: begin
               avs_readdata[STAT_OV_ALARM_BIT] = overvolt_alarm_flag;
               avs_readdata[STAT_HDRV_BIT]     = horiz_drive_out;
               avs_readdata[STAT_CDRV_BIT]     = conv_drive_out;
               avs_readdata[STAT_BLANK_BIT]    = lock_blank_composite_out[0];
               avs_readdata[STAT_LOCK_BIT]     = lock_blank_composite_out[1];
               avs_readdata[STAT_PHASE_LSB +: 2] = phase_q;
            end
            SEQ_OFS: begin
               avs_readdata[15:0] = seq_gap_q;
            end
            default: begin
               avs_readdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // Checks.
   property p_trip_needs_lines;
      @(posedge core_clk) disable iff (rst)
         $rose(ov_latched_q) |-> $past(ov_lines_q) == 2'(OV_DELAY_LINES);
   endproperty
   a_trip_needs_lines: assert property (p_trip_needs_lines)
      else $error("over-voltage tripped before two lines");

   property p_alarm_readable;
      @(posedge core_clk) disable iff (rst)
         (avs_read && avs_address == STATUS_OFS)
            |-> avs_readdata[STAT_OV_ALARM_BIT] == ov_latched_q;
   endproperty
   a_alarm_readable: assert property (p_alarm_readable)
      else $error("alarm flag not visible in status");

   property p_latch_holds;
      @(posedge core_clk) disable iff (rst)
         (ov_latched_q && sup_s && !overvolt_latch_clear) |=> ov_latched_q;
   endproperty
   a_latch_holds: assert property (p_latch_holds)
      else $error("over-voltage latch dropped without clear");

   property p_trip_drops_drives;
      @(posedge core_clk) disable iff (rst)
         (ov_latched_q && phase_q == PH_BOTH) |=> phase_q == PH_CONV_OFF;
   endproperty
   a_trip_drops_drives: assert property (p_trip_drops_drives)
      else $error("trip did not start the phase-out");

   property p_conv_needs_horiz;
      @(posedge core_clk) disable iff (rst)
         conv_drive_out |-> horiz_drive_out;
   endproperty
   a_conv_needs_horiz: assert property (p_conv_needs_horiz)
      else $error("converter drive on without horizontal drive");

   property p_conv_off_first;
      @(posedge core_clk) disable iff (rst)
         $fell(conv_drive_out) |-> horiz_drive_out;
   endproperty
   a_conv_off_first: assert property (p_conv_off_first)
      else $error("horizontal drive left before converter drive");

   property p_blank_start;
      @(posedge core_clk) disable iff (rst)
         (vs_s && !vs_q && !(vd_q && !vd_s)) |=> vblank_q;
   endproperty
   a_blank_start: assert property (p_blank_start)
      else $error("blanking did not start on vertical sync");

   property p_blank_end;
      @(posedge core_clk) disable iff (rst)
         (vd_q && !vd_s) |=> !vblank_q;
   endproperty
   a_blank_end: assert property (p_blank_end)
      else $error("blanking did not end at discharge trailing edge");

   property p_code;
      @(posedge core_clk) disable iff (rst)
         1'b1 |=> lock_blank_composite_out[1] == $past(lock_s);
   endproperty
   a_code: assert property (p_code)
      else $error("composite lock bit wrong");

   property p_forced_blank;
      @(posedge core_clk) disable iff (rst)
         (ov_latched_q || !sup_s || permanent_blank_sel) |=> lock_blank_composite_out[0];
   endproperty
   a_forced_blank: assert property (p_forced_blank)
      else $error("composite not forced to blank");

   property p_trip_holds_off;
      @(posedge core_clk) disable iff (rst)
         (ov_latched_q && phase_q == PH_OFF) |=> phase_q == PH_OFF;
   endproperty
   a_trip_holds_off: assert property (p_trip_holds_off)
      else $error("drives restarted while over-voltage latched");

   property p_horiz_leads;
      @(posedge core_clk) disable iff (rst)
         $rose(conv_drive_out) |-> $past(horiz_drive_out);
   endproperty
   a_horiz_leads: assert property (p_horiz_leads)
      else $error("converter drive came on before horizontal drive");

   property p_blank_start_discharge;
      @(posedge core_clk) disable iff (rst)
         (vd_s && !vd_q) |=> vblank_q;
   endproperty
   a_blank_start_discharge: assert property (p_blank_start_discharge)
      else $error("blanking did not start on discharge");

   property p_perm_blank;
      @(posedge core_clk) disable iff (rst)
         permanent_blank_sel |=> lock_blank_composite_out == {$past(lock_s), 1'b1};
   endproperty
   a_perm_blank: assert property (p_perm_blank)
      else $error("permanent blanking not shown with lock state");

   property p_vert_off_blank;
      @(posedge core_clk) disable iff (rst)
         !vert_drive_enable |=> lock_blank_composite_out[0];
   endproperty
   a_vert_off_blank: assert property (p_vert_off_blank)
      else $error("composite not blanked with vertical drive off");

endmodule

//--- rtl/dsb_pkg.sv
// Package for the deflection safety and blanking block: register map, field positions,
// reset values and timing counts.
// Assumes a single 10 MHz core clock and a 32-bit Avalon-MM register slave.
package dsb_pkg;

   // Register byte offsets.
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] SEQ_OFS    = 4'h8;

   // Control register fields.
   localparam int CTRL_DRIVE_ON_BIT  = 0;
   localparam int CTRL_PERM_BLK_BIT  = 1;
   localparam int CTRL_VERT_EN_BIT   = 2;
   localparam int CTRL_OV_CLEAR_BIT  = 3;

   // Status register fields.
   localparam int STAT_OV_ALARM_BIT  = 0;
   localparam int STAT_HDRV_BIT      = 1;
   localparam int STAT_CDRV_BIT      = 2;
   localparam int STAT_BLANK_BIT     = 3;
   localparam int STAT_LOCK_BIT      = 4;
   localparam int STAT_PHASE_LSB     = 8;

   // Reset values: drives requested off, permanent blanking on, vertical drive off.
   localparam logic CTRL_DRIVE_ON_RST = 1'b0;
   localparam logic CTRL_PERM_BLK_RST = 1'b1;
   localparam logic CTRL_VERT_EN_RST  = 1'b0;

   // Over-voltage must persist this many horizontal lines before it trips.
   localparam int OV_DELAY_LINES = 2;

   // Time between the two drives in the phase sequence, in microseconds.
   localparam int PHASE_GAP_US     = 100;
   localparam int CLK_MHZ          = 10;
   localparam int PHASE_GAP_CYCLES = PHASE_GAP_US * CLK_MHZ;
   localparam logic [15:0] SEQ_GAP_RST = 16'(PHASE_GAP_CYCLES);

   typedef enum logic [1:0] {
      PH_OFF,
      PH_HORIZ,
      PH_BOTH,
      PH_CONV_OFF
   } dsb_phase_type;

endpackage

//--- rtl/dsb_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a pin sampled on core_clk; output is the stable copy.
`timescale 1ns/1ps
module dsb_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

//--- dv/dsb_host_model.sv
// Register-bus master standing in for the monitor controller.
// Assumes the slave answers through avs_waitrequest on core_clk.
`timescale 1ns/1ps
module dsb_host_model (
   input  wire logic        core_clk,
   output logic [3:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
   end
   // The request is held until the edge that sees waitrequest low.
   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
endmodule

//--- dv/dsb_top_tb_top.sv
// Self-checking bench for the safety and blanking block.
// Assumes the host model drives the register bus; pins are driven here.
`timescale 1ns/1ps
module dsb_top_tb_top;
   import dsb_pkg::*;
   typedef struct {logic perm; logic vert; logic lk; logic [1:0] comp;} dsb_row_type;
   logic        core_clk, rst, ov, hs, vs, vd, lk, sup, rd, wr, wait_q, hd, cd;
   logic [3:0]  adr, be;
   logic [31:0] wdat, rdat, v;
   logic [1:0]  comp;
   int          miscompares, samples_checked;
   dsb_row_type rows[5] = '{'{1, 1, 1, 2'b11}, '{1, 1, 0, 2'b01}, '{0, 1, 1, 2'b10},
                            '{0, 1, 0, 2'b00}, '{0, 0, 1, 2'b11}};
   dsb_host_model u_host (.core_clk(core_clk), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_q));
   dsb_top u_dut (.core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_q), .overvolt_sense_in(ov), .hsync_line_in(hs),
      .vsync_in(vs), .vdischarge_in(vd), .line_pll_lock_in(lk), .supply_ok_in(sup),
      .horiz_drive_out(hd), .conv_drive_out(cd), .lock_blank_composite_out(comp));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] s);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic ctrl_wr(input logic on, input logic pb, input logic ve, input logic cl);
      v = 32'h0;
      v[CTRL_DRIVE_ON_BIT] = on;
      v[CTRL_PERM_BLK_BIT] = pb;
      v[CTRL_VERT_EN_BIT] = ve;
      v[CTRL_OV_CLEAR_BIT] = cl;
      u_host.bus_write(CTRL_OFS, v);
   endtask
   task automatic hpulse();
      hs <= 1'b1;
      step(3);
      hs <= 1'b0;
      step(3);
   endtask
   // Waits a bounded time for the drive pair, sampling away from the edge.
   task automatic wait_drv(input logic [1:0] e);
      @(negedge core_clk);
      for (int i = 0; i < 200 && {hd, cd} !== e; i++) @(negedge core_clk);
      chk2("drives", e, {hd, cd});
      @(posedge core_clk);
   endtask
   // Checks the drive pair now, with no waiting for it to change.
   task automatic drv_chk(input logic [1:0] e);
      @(negedge core_clk);
      chk2("drives", e, {hd, cd});
      @(posedge core_clk);
   endtask
   task automatic alarm(input logic e);
      u_host.bus_read(STATUS_OFS, v);
      chk32("alarm", {31'h0, e}, v & 32'h1);
   endtask
   task automatic comp_chk(input logic [1:0] e);
      @(negedge core_clk);
      chk2("composite", e, comp);
      @(posedge core_clk);
   endtask
   // Converter drive must never run without the horizontal drive.
   always @(negedge core_clk) if (rst === 1'b0 && cd !== 1'b0) chk2("order", 2'b11, {hd, cd});
   initial begin
      step(20000);
      miscompares++;
      finish_test();
   end
   initial begin
      {ov, hs, vs, vd, lk} = 5'h0;
      sup = 1'b1;
      rst = 1'b1;
      step(4);
      rst <= 1'b0;
      @(negedge core_clk);
      chk2("drives", 2'b00, {hd, cd});
      comp_chk(2'b01);
      u_host.bus_read(CTRL_OFS, v);
      chk32("ctrl", 32'h2, v);
      u_host.bus_read(4'hc, v);
      chk32("unmapped", 32'h0, v);
      foreach (rows[i]) begin
         ctrl_wr(1'b0, rows[i].perm, rows[i].vert, 1'b0);
         lk <= rows[i].lk;
         step(6);
         comp_chk(rows[i].comp);
      end
      ctrl_wr(1'b0, 1'b0, 1'b1, 1'b0);
      vs <= 1'b1;
      step(5);
      comp_chk(2'b11);
      vd <= 1'b1;
      step(3);
      vd <= 1'b0;
      step(5);
      comp_chk(2'b10);
      vs <= 1'b0;
      vd <= 1'b1;
      step(5);
      comp_chk(2'b11);
      vd <= 1'b0;
      step(5);
      comp_chk(2'b10);
      u_host.bus_write(SEQ_OFS, 32'h4);
      u_host.bus_read(SEQ_OFS, v);
      chk32("seq", 32'h4, v);
      ctrl_wr(1'b1, 1'b0, 1'b1, 1'b0);
      wait_drv(2'b10);
      wait_drv(2'b11);
      sup <= 1'b0;
      wait_drv(2'b10);
      wait_drv(2'b00);
      sup <= 1'b1;
      wait_drv(2'b11);
      ov <= 1'b1;
      hpulse();
      ov <= 1'b0;
      step(3);
      ov <= 1'b1;
      hpulse();
      step(4);
      drv_chk(2'b11);
      hpulse();
      wait_drv(2'b10);
      wait_drv(2'b00);
      alarm(1'b1);
      comp_chk(2'b11);
      ov <= 1'b0;
      step(29);
      drv_chk(2'b00);
      alarm(1'b1);
      ctrl_wr(1'b1, 1'b0, 1'b1, 1'b1);
      wait_drv(2'b11);
      alarm(1'b0);
      u_host.bus_read(STATUS_OFS, v);
      chk32("status", 32'h0000_0216, v);
      finish_test();
   end
endmodule
